// >>> inc/bfp_consts.svh
// constants for the boot flash program/erase command interpreter
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH
`define BFP_ACK 8'h06
`define BFP_CMD_DEV_INQ 8'h20
`define BFP_CMD_DEV_SEL 8'h10
`define BFP_CMD_CLK_INQ 8'h21
`define BFP_CMD_CLK_SEL 8'h11
`define BFP_CMD_DIV_INQ 8'h22
`define BFP_CMD_FRQ_INQ 8'h23
`define BFP_CMD_AREA_LO 8'h24
`define BFP_CMD_AREA_HI 8'h27
`define BFP_CMD_RATE_SEL 8'h3F
`define BFP_CMD_STATUS 8'h4F
`define BFP_CMD_TRANSITION 8'h40
`define BFP_CMD_SEL_BOOT 8'h42
`define BFP_CMD_SEL_APP 8'h43
`define BFP_CMD_PROGRAM 8'h50
`define BFP_CMD_SEL_ERASE 8'h48
`define BFP_CMD_ERASE 8'h58
`define BFP_CMD_READ 8'h52
`define BFP_CMD_SUM_BOOT 8'h4A
`define BFP_CMD_SUM_APP 8'h4B
`define BFP_CMD_BLANK_BOOT 8'h4C
`define BFP_CMD_BLANK_APP 8'h4D
`define BFP_ERR_CMD 8'h80
`define BFP_ERR_TRANSITION 8'hC0
`define BFP_ERR_SEL_BOOT 8'hC2
`define BFP_ERR_SEL_APP 8'hC3
`define BFP_ERR_SEL_ERASE 8'hC8
`define BFP_ERR_PROGRAM 8'hD0
`define BFP_ERR_ERASE 8'hD8
`define BFP_CODE_SUM 8'h11
`define BFP_CODE_BLOCK 8'h29
`define BFP_CODE_ERASE 8'h51
`define BFP_CODE_PROG 8'h53
`define BFP_CODE_SELECT 8'h54
`define BFP_ERASE_SIZE 8'h01
`define BFP_ERASE_STOP 8'hFF
`define BFP_END_ADDR 32'hFFFFFFFF
`define BFP_ADDR_BYTES 3'h4
`define BFP_DATA_BYTES 8'h80
`define BFP_BLOCK_COUNT 8'h20
`endif

// >>> inc/bfp_pkg.sv
// types for the boot flash program/erase command interpreter
package bfp_pkg;
  typedef enum logic [1:0] {
    BFP_OP_ERASE_BOTH,
    BFP_OP_LOAD,
    BFP_OP_PROGRAM,
    BFP_OP_ERASE_BLOCK
  } bfp_op_t;
  typedef enum logic [1:0] {
    BFP_RT_BOOT,
    BFP_RT_APP,
    BFP_RT_ERASE
  } bfp_routine_t;
endpackage

// >>> core/bfp_reply.sv
// one or two byte reply sender with byte handshake
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_reply
  import bfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic two_i,
  input wire logic [7:0] b0_i,
  input wire logic [7:0] b1_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic busy_o
);
  logic busy_reg, busy_next;
  logic second_reg, second_next;
  logic [7:0] hold_reg, hold_next;
  logic [7:0] data_reg, data_next;

  always_comb begin
    busy_next = busy_reg;
    second_next = second_reg;
    hold_next = hold_reg;
    data_next = data_reg;
    if (!busy_reg && start_i) begin
      busy_next = 1'b1;
      data_next = b0_i;
      hold_next = b1_i;
      second_next = two_i;
    end else if (busy_reg && tx_ready_i) begin
      if (second_reg) begin
        data_next = hold_reg;
        second_next = 1'b0;
      end else begin
        busy_next = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy_reg <= 1'b0;
      second_reg <= 1'b0;
      hold_reg <= 8'h00;
      data_reg <= 8'h00;
    end else begin
      busy_reg <= busy_next;
      second_reg <= second_next;
      hold_reg <= hold_next;
      data_reg <= data_next;
    end
  end

  assign tx_valid_o = busy_reg;
  assign tx_data_o = data_reg;
  assign busy_o = busy_reg;
endmodule

// >>> core/bfp_core.sv
// command interpreter for the boot program's programming/erasing protocol
// How it works
// - transition command erases both areas, then answers acknowledge
// - failed transition erase answers error byte with erase-failure code
// - undefined or out-of-order command answers command error plus the command
// - area inquiries accepted only after device and clock-mode selection
// - transition command after bit rate enters programming/erasing state
// - programming/erasing state accepts only its eleven commands
// - boot-area selection loads routine, acknowledges or reports load error
// - application-area selection loads routine, acknowledges or reports load error
// - programming frame: command, address, 128 data, checksum; program then ack
// - all-ones address frame ends programming, acknowledges, awaits selection
// - failed programming frame reports checksum or programming error
// - erase selection loads routine, acknowledges or reports load error
// - erase frame: command, size one, block, checksum; erase then ack
// - failed block erase reports checksum, block number or erase error
// - block number all-ones stops erasure and awaits selection
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_core
  import bfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  output logic op_req_o,
  output logic [1:0] op_kind_o,
  output logic [1:0] op_routine_o,
  output logic [31:0] op_addr_o,
  output logic [7:0] op_block_o,
  output logic [7:0] wr_data_o,
  output logic wr_valid_o,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  output logic pe_state_o,
  output logic fwd_valid_o,
  output logic [7:0] fwd_cmd_o
);
  typedef enum logic [3:0] {
    ST_CMD,
    ST_ADDR,
    ST_DATA,
    ST_PSUM,
    ST_ESIZE,
    ST_EBLOCK,
    ST_ESUM,
    ST_OP,
    ST_REPLY
  } bfp_state_t;

  bfp_state_t state_reg, state_next;
  logic dev_sel_reg, dev_sel_next;
  logic clk_sel_reg, clk_sel_next;
  logic rate_sel_reg, rate_sel_next;
  logic pe_reg, pe_next;
  logic prog_ok_reg, prog_ok_next;
  logic erase_ok_reg, erase_ok_next;
  logic [1:0] routine_reg, routine_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] sum_reg, sum_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [31:0] addr_reg, addr_next;
  logic [7:0] block_reg, block_next;
  logic size_ok_reg, size_ok_next;
  logic req_reg, req_next;
  logic [1:0] kind_reg, kind_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wvalid_reg, wvalid_next;
  logic fwd_reg, fwd_next;
  logic rdy_reg, rdy_next;
  logic rep_start, rep_two;
  logic [7:0] rep_b0, rep_b1;
  logic rep_busy;
  logic [7:0] rx_sum;
  logic take;

  // bytes are taken only while rx_ready_o is high, one per handshake
  assign take = rx_valid_i && rdy_reg;
  assign rx_sum = sum_reg + rx_data_i;

  function automatic logic pe_cmd(input logic [7:0] c);
    pe_cmd = (c == `BFP_CMD_SEL_BOOT) || (c == `BFP_CMD_SEL_APP) ||
             (c == `BFP_CMD_PROGRAM) || (c == `BFP_CMD_SEL_ERASE) ||
             (c == `BFP_CMD_ERASE) || (c == `BFP_CMD_READ) ||
             (c == `BFP_CMD_SUM_BOOT) || (c == `BFP_CMD_SUM_APP) ||
             (c == `BFP_CMD_BLANK_BOOT) || (c == `BFP_CMD_BLANK_APP) ||
             (c == `BFP_CMD_STATUS);
  endfunction

  always_comb begin
    state_next = state_reg;
    dev_sel_next = dev_sel_reg;
    clk_sel_next = clk_sel_reg;
    rate_sel_next = rate_sel_reg;
    pe_next = pe_reg;
    prog_ok_next = prog_ok_reg;
    erase_ok_next = erase_ok_reg;
    routine_next = routine_reg;
    cmd_next = cmd_reg;
    sum_next = sum_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    block_next = block_reg;
    size_ok_next = size_ok_reg;
    req_next = 1'b0;
    kind_next = kind_reg;
    wdata_next = wdata_reg;
    wvalid_next = 1'b0;
    fwd_next = 1'b0;
    rdy_next = rdy_reg;
    rep_start = 1'b0;
    rep_two = 1'b0;
    rep_b0 = `BFP_ACK;
    rep_b1 = 8'h00;
    unique case (state_reg)
      ST_CMD: begin
        if (take) begin
          cmd_next = rx_data_i;
          sum_next = rx_data_i;
          if (!pe_reg) begin
            if (rx_data_i == `BFP_CMD_TRANSITION && rate_sel_reg) begin
              kind_next = BFP_OP_ERASE_BOTH;
              req_next = 1'b1;
              rdy_next = 1'b0;
              state_next = ST_OP;
            end else if (rx_data_i == `BFP_CMD_DEV_INQ || rx_data_i == `BFP_CMD_STATUS ||
                         rx_data_i == `BFP_CMD_DEV_SEL ||
                         (dev_sel_reg && (rx_data_i == `BFP_CMD_CLK_INQ ||
                                          rx_data_i == `BFP_CMD_CLK_SEL)) ||
                         (clk_sel_reg && (rx_data_i == `BFP_CMD_DIV_INQ ||
                                          rx_data_i == `BFP_CMD_FRQ_INQ ||
                                          rx_data_i == `BFP_CMD_RATE_SEL ||
                                          (rx_data_i >= `BFP_CMD_AREA_LO &&
                                           rx_data_i <= `BFP_CMD_AREA_HI)))) begin
              // inquiry payloads are served outside; selections tracked here
              fwd_next = 1'b1;
              if (rx_data_i == `BFP_CMD_DEV_SEL) dev_sel_next = 1'b1;
              if (rx_data_i == `BFP_CMD_CLK_SEL) clk_sel_next = 1'b1;
              if (rx_data_i == `BFP_CMD_RATE_SEL) rate_sel_next = 1'b1;
            end else begin
              rep_start = 1'b1;
              rep_two = 1'b1;
              rep_b0 = `BFP_ERR_CMD;
              rep_b1 = rx_data_i;
              rdy_next = 1'b0;
              state_next = ST_REPLY;
            end
          end else if (!pe_cmd(rx_data_i) ||
                       (rx_data_i == `BFP_CMD_PROGRAM && !prog_ok_reg) ||
                       (rx_data_i == `BFP_CMD_ERASE && !erase_ok_reg)) begin
            rep_start = 1'b1;
            rep_two = 1'b1;
            rep_b0 = `BFP_ERR_CMD;
            rep_b1 = rx_data_i;
            rdy_next = 1'b0;
            state_next = ST_REPLY;
          end else if (rx_data_i == `BFP_CMD_SEL_BOOT || rx_data_i == `BFP_CMD_SEL_APP ||
                       rx_data_i == `BFP_CMD_SEL_ERASE) begin
            routine_next = (rx_data_i == `BFP_CMD_SEL_BOOT) ? BFP_RT_BOOT :
                           (rx_data_i == `BFP_CMD_SEL_APP) ? BFP_RT_APP : BFP_RT_ERASE;
            prog_ok_next = 1'b0;
            erase_ok_next = 1'b0;
            kind_next = BFP_OP_LOAD;
            req_next = 1'b1;
            rdy_next = 1'b0;
            state_next = ST_OP;
          end else if (rx_data_i == `BFP_CMD_PROGRAM) begin
            cnt_next = 8'h00;
            state_next = ST_ADDR;
          end else if (rx_data_i == `BFP_CMD_ERASE) begin
            state_next = ST_ESIZE;
          end else begin
            fwd_next = 1'b1;
          end
        end
      end
      ST_ADDR: begin
        if (take) begin
          sum_next = rx_sum;
          addr_next = {addr_reg[23:0], rx_data_i};
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == {5'h00, `BFP_ADDR_BYTES} - 8'h01) begin
            cnt_next = 8'h00;
            // end code carries no data bytes
            state_next = ({addr_reg[23:0], rx_data_i} == `BFP_END_ADDR) ? ST_PSUM : ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (take) begin
          sum_next = rx_sum;
          wdata_next = rx_data_i;
          wvalid_next = 1'b1;
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == `BFP_DATA_BYTES - 8'h01) state_next = ST_PSUM;
        end
      end
      ST_PSUM: begin
        if (take) begin
          rdy_next = 1'b0;
          if (rx_sum != 8'h00) begin
            rep_start = 1'b1;
            rep_two = 1'b1;
            rep_b0 = `BFP_ERR_PROGRAM;
            rep_b1 = `BFP_CODE_SUM;
            state_next = ST_REPLY;
          end else if (addr_reg == `BFP_END_ADDR) begin
            prog_ok_next = 1'b0;
            rep_start = 1'b1;
            state_next = ST_REPLY;
          end else begin
            kind_next = BFP_OP_PROGRAM;
            req_next = 1'b1;
            state_next = ST_OP;
          end
        end
      end
      ST_ESIZE: begin
        if (take) begin
          sum_next = rx_sum;
          size_ok_next = (rx_data_i == `BFP_ERASE_SIZE);
          state_next = ST_EBLOCK;
        end
      end
      ST_EBLOCK: begin
        if (take) begin
          sum_next = rx_sum;
          block_next = rx_data_i;
          state_next = ST_ESUM;
        end
      end
      ST_ESUM: begin
        if (take) begin
          rdy_next = 1'b0;
          state_next = ST_REPLY;
          rep_start = 1'b1;
          if (rx_sum != 8'h00) begin
            rep_two = 1'b1;
            rep_b0 = `BFP_ERR_ERASE;
            rep_b1 = `BFP_CODE_SUM;
          end else if (block_reg == `BFP_ERASE_STOP) begin
            erase_ok_next = 1'b0;
          end else if (!size_ok_reg || block_reg >= `BFP_BLOCK_COUNT) begin
            rep_two = 1'b1;
            rep_b0 = `BFP_ERR_ERASE;
            rep_b1 = `BFP_CODE_BLOCK;
          end else begin
            rep_start = 1'b0;
            kind_next = BFP_OP_ERASE_BLOCK;
            req_next = 1'b1;
            state_next = ST_OP;
          end
        end
      end
      ST_OP: begin
        // the reply waits for the flash engine so ack always follows completion
        if (op_done_i) begin
          rep_start = 1'b1;
          state_next = ST_REPLY;
          unique case (kind_reg)
            BFP_OP_ERASE_BOTH: begin
              if (op_fail_i) begin
                rep_two = 1'b1;
                rep_b0 = `BFP_ERR_TRANSITION;
                rep_b1 = `BFP_CODE_ERASE;
              end else begin
                pe_next = 1'b1;
              end
            end
            BFP_OP_LOAD: begin
              if (op_fail_i) begin
                rep_two = 1'b1;
                rep_b0 = (cmd_reg == `BFP_CMD_SEL_BOOT) ? `BFP_ERR_SEL_BOOT :
                         (cmd_reg == `BFP_CMD_SEL_APP) ? `BFP_ERR_SEL_APP :
                         `BFP_ERR_SEL_ERASE;
                rep_b1 = `BFP_CODE_SELECT;
              end else if (routine_reg == BFP_RT_ERASE) begin
                erase_ok_next = 1'b1;
              end else begin
                prog_ok_next = 1'b1;
              end
            end
            BFP_OP_PROGRAM: begin
              if (op_fail_i) begin
                rep_two = 1'b1;
                rep_b0 = `BFP_ERR_PROGRAM;
                rep_b1 = `BFP_CODE_PROG;
                prog_ok_next = 1'b0;
              end
            end
            BFP_OP_ERASE_BLOCK: begin
              if (op_fail_i) begin
                rep_two = 1'b1;
                rep_b0 = `BFP_ERR_ERASE;
                rep_b1 = `BFP_CODE_ERASE;
              end
            end
          endcase
        end
      end
      ST_REPLY: begin
        // next command is held off until the reply has fully left
        if (!rep_busy && !rep_start) begin
          rdy_next = 1'b1;
          state_next = ST_CMD;
        end
      end
      default: state_next = ST_CMD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_CMD;
      dev_sel_reg <= 1'b0;
      clk_sel_reg <= 1'b0;
      rate_sel_reg <= 1'b0;
      pe_reg <= 1'b0;
      prog_ok_reg <= 1'b0;
      erase_ok_reg <= 1'b0;
      routine_reg <= BFP_RT_BOOT;
      cmd_reg <= 8'h00;
      sum_reg <= 8'h00;
      cnt_reg <= 8'h00;
      addr_reg <= 32'h00000000;
      block_reg <= 8'h00;
      size_ok_reg <= 1'b0;
      req_reg <= 1'b0;
      kind_reg <= BFP_OP_ERASE_BOTH;
      wdata_reg <= 8'h00;
      wvalid_reg <= 1'b0;
      fwd_reg <= 1'b0;
      rdy_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      dev_sel_reg <= dev_sel_next;
      clk_sel_reg <= clk_sel_next;
      rate_sel_reg <= rate_sel_next;
      pe_reg <= pe_next;
      prog_ok_reg <= prog_ok_next;
      erase_ok_reg <= erase_ok_next;
      routine_reg <= routine_next;
      cmd_reg <= cmd_next;
      sum_reg <= sum_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      block_reg <= block_next;
      size_ok_reg <= size_ok_next;
      req_reg <= req_next;
      kind_reg <= kind_next;
      wdata_reg <= wdata_next;
      wvalid_reg <= wvalid_next;
      fwd_reg <= fwd_next;
      rdy_reg <= rdy_next;
    end
  end

  bfp_reply bfp_reply_inst (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(rep_start),
    .two_i(rep_two),
    .b0_i(rep_b0),
    .b1_i(rep_b1),
    .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o),
    .busy_o(rep_busy)
  );

  assign rx_ready_o = rdy_reg;
  assign op_req_o = req_reg;
  assign op_kind_o = kind_reg;
  assign op_routine_o = routine_reg;
  assign op_addr_o = addr_reg;
  assign op_block_o = block_reg;
  assign wr_data_o = wdata_reg;
  assign wr_valid_o = wvalid_reg;
  assign pe_state_o = pe_reg;
  assign fwd_valid_o = fwd_reg;
  assign fwd_cmd_o = cmd_reg;
endmodule

// >>> tb/bfp_far_model.sv
// far-side model: flash engine answering operations and a reply sink that can stall
`timescale 1ns/1ps
module bfp_far_model (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic op_req_i,
  input wire logic fail_i,
  input wire logic slow_i,
  input wire logic [3:0] dly_i,
  output logic op_done_o,
  output logic op_fail_o,
  output logic tx_ready_o
);
  logic busy;
  logic [3:0] cnt;
  logic [1:0] ph;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      ph <= 2'h0;
      op_done_o <= 1'b0;
      op_fail_o <= 1'b0;
    end else begin
      ph <= ph + 2'h1;
      op_done_o <= 1'b0;
      // fail flag is only meaningful with done, so it shows junk otherwise
      op_fail_o <= ~fail_i;
      if (op_req_i) begin
        busy <= 1'b1;
        cnt <= dly_i;
      end else if (busy && cnt == 4'h0) begin
        busy <= 1'b0;
        op_done_o <= 1'b1;
        op_fail_o <= fail_i;
      end else if (busy) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // slow mode accepts one reply byte in four cycles
  assign tx_ready_o = !slow_i || (ph == 2'h3);
endmodule

// >>> tb/bfp_core_asserts.sv
// concurrent checks on the command interpreter ports
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_core_asserts
  import bfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic op_req_o,
  input wire logic [1:0] op_kind_o,
  input wire logic [1:0] op_routine_o,
  input wire logic [31:0] op_addr_o,
  input wire logic [7:0] op_block_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_valid_o,
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic pe_state_o,
  input wire logic fwd_valid_o,
  input wire logic [7:0] fwd_cmd_o
);
  logic [7:0] wr_cnt_reg;
  // a reply clears the count so a refused frame does not leak into the next
  always_ff @(posedge clk_i) begin
    if (srst_i || op_req_o || tx_valid_o) begin
      wr_cnt_reg <= 8'h00;
    end else if (wr_valid_o) begin
      wr_cnt_reg <= wr_cnt_reg + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  AST_RESET_IDLE: assert property (
    $fell(srst_i) |-> rx_ready_o && !tx_valid_o && !pe_state_o)
    else $error("outputs not idle after reset");
  AST_TX_HOLD: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped before acceptance");
  AST_TX_BLOCKS_RX: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("byte intake open during reply");
  AST_OP_PULSE: assert property (op_req_o |=> !op_req_o [*2])
    else $error("operation request not a single pulse");
  AST_ACK_AFTER_DONE: assert property (
    op_done_i && !op_fail_i |=> tx_valid_o && tx_data_o == `BFP_ACK)
    else $error("no acknowledge after finished operation");
  AST_TRANS_FAIL: assert property (
    op_done_i && op_fail_i && op_kind_o == BFP_OP_ERASE_BOTH
    |=> tx_valid_o && tx_data_o == `BFP_ERR_TRANSITION) else $error("bad transition error");
  AST_PROG_FAIL: assert property (
    op_done_i && op_fail_i && op_kind_o == BFP_OP_PROGRAM
    |=> tx_valid_o && tx_data_o == `BFP_ERR_PROGRAM) else $error("bad program error");
  AST_WR_COUNT: assert property (
    op_req_o && op_kind_o == BFP_OP_PROGRAM |-> wr_cnt_reg == `BFP_DATA_BYTES)
    else $error("program op without 128 data bytes");
  AST_BOTH_BEFORE_PE: assert property (
    op_req_o && op_kind_o == BFP_OP_ERASE_BOTH |-> !pe_state_o)
    else $error("area erase outside inquiry state");
  AST_PE_OPS: assert property (op_req_o && op_kind_o != BFP_OP_ERASE_BOTH |-> pe_state_o)
    else $error("flash op outside programming state");
  AST_PE_HOLD: assert property (pe_state_o |=> pe_state_o)
    else $error("programming state left");
  AST_BLOCK_RANGE: assert property (
    op_req_o && op_kind_o == BFP_OP_ERASE_BLOCK
    |-> op_block_o < `BFP_BLOCK_COUNT) else $error("erase of invalid block");
  AST_FWD_QUIET: assert property (fwd_valid_o |-> rx_ready_o ##1 !tx_valid_o)
    else $error("reply sent for forwarded command");
  COV_PROG: cover property (op_req_o && op_kind_o == BFP_OP_PROGRAM);
  COV_ERASE: cover property (op_req_o && op_kind_o == BFP_OP_ERASE_BLOCK);
  COV_PE: cover property ($rose(pe_state_o));
  COV_CMD_ERR: cover property (tx_valid_o && tx_data_o == `BFP_ERR_CMD);
endmodule
bind bfp_core bfp_core_asserts bfp_core_asserts_inst (.clk_i(clk_i), .srst_i(srst_i),
  .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
  .op_req_o(op_req_o), .op_kind_o(op_kind_o), .op_routine_o(op_routine_o),
  .op_addr_o(op_addr_o), .op_block_o(op_block_o), .wr_data_o(wr_data_o),
  .wr_valid_o(wr_valid_o), .op_done_i(op_done_i), .op_fail_i(op_fail_i),
  .pe_state_o(pe_state_o), .fwd_valid_o(fwd_valid_o), .fwd_cmd_o(fwd_cmd_o));

// >>> tb/bfp_core_tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
`include "bfp_consts.svh"
module bfp_core_tb
  import bfp_pkg::*;
;
  typedef logic [7:0] bfp_tb_q_t[$];
  logic clk_i, srst_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, op_req_o, wr_valid_o;
  logic op_done_i, op_fail_i, pe_state_o, fwd_valid_o, fail, slow;
  logic [7:0] rx_data_i, tx_data_o, op_block_o, wr_data_o, fwd_cmd_o, blk;
  logic [1:0] op_kind_o, op_routine_o;
  logic [31:0] op_addr_o, addr;
  logic [3:0] dly;
  int fails, tests_run;
  bfp_tb_q_t rep_q, fwd_q, wr_q, fr, dat;
  bfp_core bfp_core_inst (.clk_i(clk_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .op_req_o(op_req_o), .op_kind_o(op_kind_o),
    .op_routine_o(op_routine_o), .op_addr_o(op_addr_o), .op_block_o(op_block_o),
    .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .op_done_i(op_done_i),
    .op_fail_i(op_fail_i), .pe_state_o(pe_state_o), .fwd_valid_o(fwd_valid_o),
    .fwd_cmd_o(fwd_cmd_o));
  bfp_far_model bfp_far_model_inst (.clk_i(clk_i), .srst_i(srst_i), .op_req_i(op_req_o),
    .fail_i(fail), .slow_i(slow), .dly_i(dly), .op_done_o(op_done_i), .op_fail_o(op_fail_i),
    .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (tx_valid_o && tx_ready_i) rep_q.push_back(tx_data_o);
    if (fwd_valid_o) fwd_q.push_back(fwd_cmd_o);
    if (wr_valid_o) wr_q.push_back(wr_data_o);
  end
  function automatic bfp_tb_q_t sealed(bfp_tb_q_t b);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s += b[i];
    b.push_back(8'h00 - s);
    return b;
  endfunction
  task conclude();
    $display("checks run %0d, failed %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task send_byte(input logic [7:0] b);
    int w;
    rx_valid_i = 1'b1;
    rx_data_i = b;
    w = 0;
    while (rx_ready_o !== 1'b1 && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    if (w >= 300) chk(w, 0);
    @(negedge clk_i);
  endtask
  // sends a frame, then expects n reply bytes and nothing more
  task run(input bfp_tb_q_t f, input int n, input logic [7:0] e0, input logic [7:0] e1);
    int w;
    rep_q.delete();
    fwd_q.delete();
    foreach (f[i]) send_byte(f[i]);
    rx_valid_i = 1'b0;
    w = 0;
    while (rep_q.size() < n && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    repeat (4) @(negedge clk_i);
    chk(rep_q.size(), n);
    if (n > 0 && rep_q.size() == n) chk(rep_q[0], e0);
    if (n > 1 && rep_q.size() == n) chk(rep_q[1], e1);
  endtask
  task fwd(input logic [7:0] c);
    run('{c}, 0, 8'h00, 8'h00);
    chk(fwd_q.size(), 1);
    chk(fwd_q.size() > 0 ? fwd_q[0] : 8'h00, c);
  endtask
  task inquiry();
    foreach (dat[i]) fwd(dat[i]);
  endtask
  task prog(input int mode);
    addr = $urandom() & 32'h7FFFFF80;
    dat.delete();
    for (int i = 0; i < 128; i++) dat.push_back(i >= 112 ? 8'hFF : 8'($urandom()));
    fr = sealed({8'h50, addr[31:24], addr[23:16], addr[15:8], addr[7:0], dat});
    if (mode == 1) fr[132] ^= 8'h01;
    wr_q.delete();
    fail = (mode == 2);
    dly = 4'($urandom());
    run(fr, mode > 0 ? 2 : 1, mode > 0 ? 8'hD0 : 8'h06, mode == 1 ? 8'h11 : 8'h53);
    // engine failure must not carry over into the next operation
    fail = 1'b0;
    if (mode == 0) begin
      chk(op_addr_o, addr);
      chk(op_kind_o, BFP_OP_PROGRAM);
      chk(wr_q.size(), 128);
      if (wr_q.size() == 128) foreach (dat[i]) chk(wr_q[i], dat[i]);
    end
  endtask
  initial begin
    srst_i = 1'b1;
    rx_valid_i = 1'b0;
    rx_data_i = 8'h00;
    fail = 1'b0;
    slow = 1'b0;
    dly = 4'h2;
    fails = 0;
    tests_run = 0;
    addr = $urandom(31143);
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    run('{8'h11}, 2, 8'h80, 8'h11);
    run('{8'h40}, 2, 8'h80, 8'h40);
    dat = '{8'h20, 8'h10, 8'h21, 8'h11, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h3F, 8'h4F};
    inquiry();
    fail = 1'b1;
    run('{8'h40}, 2, 8'hC0, 8'h51);
    chk(pe_state_o, 1'b0);
    srst_i = 1'b1;
    @(negedge clk_i);
    srst_i = 1'b0;
    inquiry();
    fail = 1'b0;
    slow = 1'b1;
    run('{8'h40}, 1, 8'h06, 8'h00);
    chk(pe_state_o, 1'b1);
    run('{8'h20}, 2, 8'h80, 8'h20);
    run('{8'h50}, 2, 8'h80, 8'h50);
    dat = '{8'h52, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4F};
    inquiry();
    fail = 1'b1;
    run('{8'h42}, 2, 8'hC2, 8'h54);
    fail = 1'b0;
    run('{8'h43}, 1, 8'h06, 8'h00);
    chk(op_routine_o, BFP_RT_APP);
    prog(0);
    prog(0);
    prog(1);
    prog(2);
    run('{8'h50}, 2, 8'h80, 8'h50);
    run('{8'h42}, 1, 8'h06, 8'h00);
    chk(op_routine_o, BFP_RT_BOOT);
    run(sealed('{8'h50, 8'hFF, 8'hFF, 8'hFF, 8'hFF}), 1, 8'h06, 8'h00);
    run('{8'h50}, 2, 8'h80, 8'h50);
    fail = 1'b1;
    run('{8'h48}, 2, 8'hC8, 8'h54);
    fail = 1'b0;
    run('{8'h48}, 1, 8'h06, 8'h00);
    blk = 8'($urandom_range(31));
    run(sealed('{8'h58, 8'h01, blk}), 1, 8'h06, 8'h00);
    chk(op_block_o, blk);
    run(sealed('{8'h58, 8'h01, 8'h20}), 2, 8'hD8, 8'h29);
    run(sealed('{8'h58, 8'h02, 8'h03}), 2, 8'hD8, 8'h29);
    fr = sealed('{8'h58, 8'h01, 8'h00});
    fr[3] ^= 8'h80;
    run(fr, 2, 8'hD8, 8'h11);
    fail = 1'b1;
    run(sealed('{8'h58, 8'h01, 8'h03}), 2, 8'hD8, 8'h51);
    fail = 1'b0;
    run('{8'h48}, 1, 8'h06, 8'h00);
    run(sealed('{8'h58, 8'h01, 8'hFF}), 1, 8'h06, 8'h00);
    run('{8'h58}, 2, 8'h80, 8'h58);
    conclude();
  end
  // generous bound: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    conclude();
  end
endmodule
